//--- lsf_break_det.sv
// line status flags: break detector, one pulse per low period of a full frame
// assumes rx_level is already synchronised to mclk
`timescale 1ns/1ns
module lsf_break_det #(
  parameter int FRAME_CYCLES = lsf_pkg::BREAK_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // line and event
  input wire logic rx_level,
  output logic break_pulse
);
  localparam int CW = $clog2(FRAME_CYCLES + 1);

  lsf_pkg::lsf_brk_state_t st_ff, nxt_st;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic pulse_ff, nxt_pulse;

  assign break_pulse = pulse_ff;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_pulse = 1'b0;
    unique case (st_ff)
      lsf_pkg::BRK_IDLE:
      begin
        nxt_cnt = CW'(1);
        if (!rx_level)
        begin
          nxt_st = lsf_pkg::BRK_COUNT;
        end
      end
      lsf_pkg::BRK_COUNT:
      begin
        if (rx_level)
        begin
          nxt_st = lsf_pkg::BRK_IDLE;
        end
        else if (cnt_ff == CW'(FRAME_CYCLES))
        begin
          nxt_st = lsf_pkg::BRK_HELD;
          nxt_pulse = 1'b1;
        end
        else
        begin
          nxt_cnt = cnt_ff + CW'(1);
        end
      end
      lsf_pkg::BRK_HELD:
      begin
        // no further event until the line returns high
        if (rx_level)
        begin
          nxt_st = lsf_pkg::BRK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff <= lsf_pkg::BRK_IDLE;
      cnt_ff <= '0;
      pulse_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      pulse_ff <= nxt_pulse;
    end
  end

endmodule : lsf_break_det

//--- lsf_fifo.sv
// line status flags: synchronous fifo, valid/ready on both sides
// assumes DEPTH is a power of two; pointers wrap by overflow
`timescale 1ns/1ns
module lsf_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // stream
  lsf_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign f.wr_ready = cnt_ff != CW'(DEPTH);
  assign f.rd_valid = cnt_ff != '0;
  assign f.rd_data = mem_ff[rp_ff];
  assign f.count = cnt_ff;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    push = f.wr_valid & f.wr_ready;
    pop = f.rd_ready & f.rd_valid;
    nxt_mem = mem_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;
    if (push)
    begin
      nxt_mem[wp_ff] = f.wr_data;
      nxt_wp = wp_ff + AW'(1);
    end
    if (pop)
    begin
      nxt_rp = rp_ff + AW'(1);
    end
    if (push && !pop)
    begin
      nxt_cnt = cnt_ff + CW'(1);
    end
    else if (pop && !push)
    begin
      nxt_cnt = cnt_ff - CW'(1);
    end
  end

  // storage carries no reset: only pointers and count need a defined value
  always_ff @(posedge mclk)
  begin
    mem_ff <= nxt_mem;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : lsf_fifo

//--- lsf_fifo_if.sv
// line status flags: carrier between the receive fifo and its user
// assumes both ends sit on mclk
`timescale 1ns/1ns
interface lsf_fifo_if #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
);
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  logic [$clog2(DEPTH):0] count;

  modport fifo (
    input wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data, count
  );
  modport user (
    output wr_valid, wr_data, rd_ready,
    input wr_ready, rd_valid, rd_data, count
  );
endinterface : lsf_fifo_if

//--- lsf_host.sv
// host model: register strobes and finished receive characters
// assumes calls come from one process
`timescale 1ns/1ns
module lsf_host (
  // clock
  input logic mclk,
  // host strobes
  output logic host_thr_wr,
  output logic host_tx_fifo_wr,
  output logic host_rx_rd,
  output logic host_lsr_rd,
  // receive path
  output logic rx_char_done,
  output logic [7:0] rx_char,
  output logic rx_parity_err,
  output logic rx_framing_err
);
  logic [3:0] stb;
  assign {host_lsr_rd, host_rx_rd, host_tx_fifo_wr, host_thr_wr} = stb;
  initial
  begin
    stb = 4'h0;
    rx_char_done = 1'b0;
    rx_char = 8'h00;
    rx_parity_err = 1'b0;
    rx_framing_err = 1'b0;
  end

  task automatic pulse(input int i);
    @(posedge mclk);
    stb[i] <= 1'b1;
    @(posedge mclk);
    stb[i] <= 1'b0;
  endtask : pulse

  task automatic put(input logic [7:0] d, input logic pe, input logic fe);
    @(posedge mclk);
    rx_char_done <= 1'b1;
    rx_char <= d;
    rx_parity_err <= pe;
    rx_framing_err <= fe;
    @(posedge mclk);
    rx_char_done <= 1'b0;
    // unqualified data is garbage, not the last value
    rx_char <= ~d;
    rx_parity_err <= ~pe;
    rx_framing_err <= ~fe;
  endtask : put
endmodule : lsf_host

//--- lsf_line_status.sv
// line status flags for one uart channel: builds the line_status byte
// assumes strobes come from logic on mclk; only rx_pin is asynchronous
`timescale 1ns/1ns
module lsf_line_status #(
  parameter int BREAK_CYCLES = lsf_pkg::BREAK_CYCLES,
  parameter int RX_DEPTH = lsf_pkg::RX_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // configuration
  input wire logic fifo_mode,
  input wire logic thr_irq_en,
  // host strobes
  input wire logic host_thr_wr,
  input wire logic host_tx_fifo_wr,
  input wire logic host_rx_rd,
  input wire logic host_lsr_rd,
  // transmit path
  input wire logic tx_load,
  input wire logic tx_shift_busy,
  input wire logic tx_fifo_empty,
  // receive path
  input wire logic rx_pin,
  input wire logic rx_char_done,
  input wire logic [7:0] rx_char,
  input wire logic rx_parity_err,
  input wire logic rx_framing_err,
  // status
  output logic [7:0] line_status_ff,
  output logic [7:0] rx_data_ff,
  output logic thr_irq_ff
);
  localparam int CW = $clog2(RX_DEPTH) + 1;

  ////////////////////////////////////////////////////////////////////////////////
  // receive line synchroniser, idles high
  logic rx_meta_ff, rx_sync_ff;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
    end
    else
    begin
      rx_meta_ff <= rx_pin;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  logic brk_pulse;

  lsf_break_det #(
    .FRAME_CYCLES(BREAK_CYCLES)
  ) u_brk (
    .mclk(mclk),
    .rstn(rstn),
    .rx_level(rx_sync_ff),
    .break_pulse(brk_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // receive store: one entry deep without fifo, RX_DEPTH with it
  lsf_fifo_if #(.WIDTH(lsf_pkg::ENTRY_W), .DEPTH(RX_DEPTH)) rxq ();

  lsf_fifo #(
    .WIDTH(lsf_pkg::ENTRY_W),
    .DEPTH(RX_DEPTH)
  ) u_rxq (
    .mclk(mclk),
    .rstn(rstn),
    .f(rxq.fifo)
  );

  logic push_req, room, push, pop;
  logic [lsf_pkg::ENTRY_W-1:0] entry;
  logic [lsf_pkg::ENTRY_W-1:0] head;

  always_comb
  begin
    push_req = rx_char_done | brk_pulse;
    // a break outranks a character ending in the same cycle
    if (brk_pulse)
    begin
      entry = lsf_pkg::BREAK_ENTRY;
    end
    else
    begin
      entry = {1'b0, rx_framing_err, rx_parity_err, rx_char};
    end
    room = rxq.wr_ready & (fifo_mode | (rxq.count == '0));
    push = push_req & room;
    pop = host_rx_rd & rxq.rd_valid;
    head = rxq.rd_valid ? rxq.rd_data : '0;
  end

  assign rxq.wr_valid = push;
  assign rxq.wr_data = entry;
  assign rxq.rd_ready = host_rx_rd;

  ////////////////////////////////////////////////////////////////////////////////
  // per-channel flag state; a second channel is a second instance
  logic thre_ff, nxt_thre;
  logic ovr_ff, nxt_ovr;
  logic [CW-1:0] err_cnt_ff, nxt_err_cnt;
  logic [7:0] nxt_ls;
  logic [7:0] nxt_rx_data;
  logic nxt_irq;
  logic hold_empty, tx_empty;

  always_comb
  begin
    nxt_thre = thre_ff;
    if (host_thr_wr)
    begin
      nxt_thre = 1'b0;
    end
    if (tx_load)
    begin
      nxt_thre = 1'b1;
    end

    nxt_ovr = ovr_ff;
    if (host_lsr_rd)
    begin
      nxt_ovr = 1'b0;
    end
    // the shift register is overwritten outside; here the loss is recorded
    if (push_req && !room)
    begin
      nxt_ovr = 1'b1;
    end

    nxt_err_cnt = err_cnt_ff;
    if (push && lsf_pkg::lsf_entry_err(entry))
    begin
      nxt_err_cnt = nxt_err_cnt + CW'(1);
    end
    if (pop && lsf_pkg::lsf_entry_err(head))
    begin
      nxt_err_cnt = nxt_err_cnt - CW'(1);
    end

    if (fifo_mode)
    begin
      // a write in flight already counts as not empty
      hold_empty = tx_fifo_empty & ~host_tx_fifo_wr;
      tx_empty = tx_fifo_empty & ~tx_shift_busy;
    end
    else
    begin
      hold_empty = thre_ff;
      tx_empty = thre_ff & ~tx_shift_busy;
    end

    nxt_ls = '0;
    nxt_ls[lsf_pkg::LS_RX_READY] = rxq.rd_valid;
    nxt_ls[lsf_pkg::LS_OVERRUN] = ovr_ff;
    nxt_ls[lsf_pkg::LS_PARITY] = head[lsf_pkg::ENTRY_PE];
    nxt_ls[lsf_pkg::LS_FRAMING] = head[lsf_pkg::ENTRY_FE];
    nxt_ls[lsf_pkg::LS_BREAK] = head[lsf_pkg::ENTRY_BI];
    nxt_ls[lsf_pkg::LS_HOLD_EMPTY] = hold_empty;
    nxt_ls[lsf_pkg::LS_TX_EMPTY] = tx_empty;
    nxt_ls[lsf_pkg::LS_FIFO_ERR] = fifo_mode & (err_cnt_ff != '0);

    nxt_irq = hold_empty & thr_irq_en;
    nxt_rx_data = head[lsf_pkg::DATA_W-1:0];
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      thre_ff <= 1'b1;
      ovr_ff <= 1'b0;
      err_cnt_ff <= '0;
      line_status_ff <= lsf_pkg::LINE_STATUS_RESET;
      rx_data_ff <= lsf_pkg::RX_DATA_RESET;
      thr_irq_ff <= 1'b0;
    end
    else
    begin
      thre_ff <= nxt_thre;
      ovr_ff <= nxt_ovr;
      err_cnt_ff <= nxt_err_cnt;
      line_status_ff <= nxt_ls;
      rx_data_ff <= nxt_rx_data;
      thr_irq_ff <= nxt_irq;
    end
  end

endmodule : lsf_line_status

//--- lsf_monitor.sv
// checker for the line status block, ports only
// assumes the bind below and one clock domain
`timescale 1ns/1ns
module lsf_monitor (
  // clock and reset
  input logic mclk,
  input logic rstn,
  // control and events
  input logic fifo_mode,
  input logic thr_irq_en,
  input logic host_thr_wr,
  input logic host_rx_rd,
  input logic tx_load,
  input logic tx_shift_busy,
  input logic tx_fifo_empty,
  input logic rx_char_done,
  // status
  input logic [7:0] line_status_ff,
  input logic [7:0] rx_data_ff,
  input logic thr_irq_ff
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  wire [7:0] ls = line_status_ff;

  chk_thr_clear: assert property (host_thr_wr && !tx_load && !fifo_mode |=> ##1 !ls[5])
    else $error("holding empty kept");
  chk_thr_set: assert property (tx_load && !fifo_mode |=> ##1 ls[5])
    else $error("holding empty not set");
  chk_tx_busy: assert property (tx_shift_busy |=> !ls[6])
    else $error("tx empty while busy");
  chk_fifo_hold: assert property (fifo_mode && !tx_fifo_empty |=> !ls[5])
    else $error("holding empty with data");
  chk_irq_gate: assert property (!$past(thr_irq_en) |-> !thr_irq_ff)
    else $error("irq while disabled");
  // a pop just before would make ls[0] stale
  chk_ovr_set: assert property (rx_char_done && !fifo_mode && ls[0] && !$past(host_rx_rd)
    |=> ##1 ls[1])
    else $error("overrun missed");
  chk_ovr_keep: assert property ($rose(ls[1]) |-> $stable(rx_data_ff))
    else $error("stored data hit");
  chk_err_head: assert property (|ls[4:2] |-> ls[0])
    else $error("error flag without data");
  chk_rx_empty: assert property (!ls[0] |-> rx_data_ff == 8'h00)
    else $error("data while empty");

  cover property (ls[1]);
  cover property (ls[4]);
  cover property (ls[7]);
endmodule : lsf_monitor

bind lsf_line_status lsf_monitor u_lsf_monitor (
  .mclk(mclk), .rstn(rstn), .fifo_mode(fifo_mode), .thr_irq_en(thr_irq_en),
  .host_thr_wr(host_thr_wr), .host_rx_rd(host_rx_rd), .tx_load(tx_load),
  .tx_shift_busy(tx_shift_busy), .tx_fifo_empty(tx_fifo_empty),
  .rx_char_done(rx_char_done), .line_status_ff(line_status_ff),
  .rx_data_ff(rx_data_ff), .thr_irq_ff(thr_irq_ff)
);

//--- lsf_pkg.sv
// line status flags: shared constants, entry layout, break timing and state type
// assumes one 10 MHz system clock (mclk) and an active-low asynchronous reset (rstn)
package lsf_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // line_status bit positions
  localparam int LS_RX_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  localparam int LS_FRAMING = 3;
  localparam int LS_BREAK = 4;
  localparam int LS_HOLD_EMPTY = 5;
  localparam int LS_TX_EMPTY = 6;
  localparam int LS_FIFO_ERR = 7;
  localparam logic [7:0] LINE_STATUS_RESET = 8'h60;

  ////////////////////////////////////////////////////////////////////////////////
  // receive entry: character plus its three error marks
  localparam int DATA_W = 8;
  localparam int ENTRY_PE = 8;
  localparam int ENTRY_FE = 9;
  localparam int ENTRY_BI = 10;
  localparam int ENTRY_W = 11;
  localparam int RX_DEPTH = 16;
  localparam logic [ENTRY_W-1:0] BREAK_ENTRY = 11'h400;
  localparam logic [DATA_W-1:0] RX_DATA_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // break timing: one character frame of low line
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_TIME_NS = 104167;
  localparam int FRAME_BITS = 10;
  localparam int FRAME_TIME_NS = BIT_TIME_NS * FRAME_BITS;
  localparam int BREAK_CYCLES = (FRAME_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {BRK_IDLE, BRK_COUNT, BRK_HELD} lsf_brk_state_t;

  function automatic logic lsf_entry_err(input logic [ENTRY_W-1:0] e);
    lsf_entry_err = e[ENTRY_PE] | e[ENTRY_FE] | e[ENTRY_BI];
  endfunction : lsf_entry_err

endpackage : lsf_pkg

//--- testbench.sv
// testbench: tx flags, rx holding, fifo fill and drain, break
// assumes the host model and the bound checker
`timescale 1ns/1ns
module testbench;
  logic mclk, rstn, fifo_mode, thr_irq_en, tx_load, tx_shift_busy, tx_fifo_empty, rx_pin;
  logic thr_wr, txf_wr, rx_rd, lsr_rd, done, pe, fe, irq;
  logic [7:0] rx_char, ls, rxd;
  int num_errors = 0;
  int total_checks = 0;
  always #50 mclk = ~mclk;

  lsf_line_status #(.BREAK_CYCLES(20), .RX_DEPTH(16)) u_lsf_line_status (
    .mclk(mclk), .rstn(rstn), .fifo_mode(fifo_mode), .thr_irq_en(thr_irq_en),
    .host_thr_wr(thr_wr), .host_tx_fifo_wr(txf_wr), .host_rx_rd(rx_rd),
    .host_lsr_rd(lsr_rd), .tx_load(tx_load), .tx_shift_busy(tx_shift_busy),
    .tx_fifo_empty(tx_fifo_empty), .rx_pin(rx_pin), .rx_char_done(done),
    .rx_char(rx_char), .rx_parity_err(pe), .rx_framing_err(fe),
    .line_status_ff(ls), .rx_data_ff(rxd), .thr_irq_ff(irq));
  lsf_host u_lsf_host (
    .mclk(mclk), .host_thr_wr(thr_wr), .host_tx_fifo_wr(txf_wr), .host_rx_rd(rx_rd),
    .host_lsr_rd(lsr_rd), .rx_char_done(done), .rx_char(rx_char),
    .rx_parity_err(pe), .rx_framing_err(fe));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (16) @(posedge mclk);
    chk(ls, 8'h60);
    chk(rxd, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rstn <= 1'b1;
    settle(2);
    chk(ls, 8'h60);
  endtask : t_reset

  task automatic t_tx;
    u_lsf_host.pulse(0);
    settle(1);
    chk(ls & 8'h60, 8'h00);
    chk({7'h00, irq}, 8'h00);
    @(posedge mclk);
    tx_load <= 1'b1;
    tx_shift_busy <= 1'b1;
    @(posedge mclk);
    tx_load <= 1'b0;
    settle(2);
    chk(ls & 8'h60, 8'h20);
    chk({7'h00, irq}, 8'h01);
    @(posedge mclk);
    thr_irq_en <= 1'b0;
    tx_shift_busy <= 1'b0;
    settle(2);
    chk(ls & 8'h60, 8'h60);
    chk({7'h00, irq}, 8'h00);
  endtask : t_tx

  task automatic t_rx;
    u_lsf_host.put(8'h41, 1'b1, 1'b1);
    settle(1);
    chk(ls & 8'h9F, 8'h0D);
    chk(rxd, 8'h41);
    u_lsf_host.put(8'h42, 1'b0, 1'b0);
    settle(1);
    chk(ls & 8'h9F, 8'h0F);
    chk(rxd, 8'h41);
    u_lsf_host.pulse(3);
    settle(1);
    chk(ls & 8'h9F, 8'h0D);
    u_lsf_host.pulse(2);
    settle(1);
    chk(ls & 8'h9F, 8'h00);
  endtask : t_rx

  task automatic t_fifo;
    @(posedge mclk);
    fifo_mode <= 1'b1;
    tx_fifo_empty <= 1'b0;
    settle(2);
    chk(ls & 8'h60, 8'h00);
    @(posedge mclk);
    tx_fifo_empty <= 1'b1;
    tx_shift_busy <= 1'b1;
    settle(2);
    chk(ls & 8'h60, 8'h20);
    @(posedge mclk);
    tx_shift_busy <= 1'b0;
    settle(2);
    chk(ls & 8'h60, 8'h60);
    u_lsf_host.pulse(1);
    settle(0);
    chk(ls & 8'h20, 8'h00);
    // the seventeenth character finds the store full
    for (int i = 0; i < 17; i++)
      u_lsf_host.put(8'h10 + i[7:0], i == 1, i == 2);
    settle(1);
    chk(ls & 8'h9F, 8'h83);
    for (int i = 0; i < 16; i++)
    begin
      chk(ls & 8'h9D, {i < 3, 3'h0, i == 2, i == 1, 2'b01});
      chk(rxd, 8'h10 + i[7:0]);
      u_lsf_host.pulse(2);
      settle(1);
    end
    chk(ls & 8'h9D, 8'h00);
    u_lsf_host.pulse(3);
  endtask : t_fifo

  task automatic t_brk;
    @(posedge mclk);
    rx_pin <= 1'b0;
    // look just after each edge, once the flags have settled
    for (int n = 0; n < 100 && ls[4] !== 1'b1; n++)
      settle(1);
    if (ls[4] !== 1'b1)
    begin
      num_errors++;
      $display("[FAIL] %0t break flag never rose", $time);
      end_of_test();
    end
    // several frames long, still one entry
    repeat (100) @(posedge mclk);
    rx_pin <= 1'b1;
    settle(8);
    chk(ls & 8'h9D, 8'h91);
    chk(rxd, 8'h00);
    u_lsf_host.pulse(2);
    settle(1);
    chk(ls & 8'h9D, 8'h00);
  endtask : t_brk

  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    fifo_mode = 1'b0;
    thr_irq_en = 1'b1;
    tx_load = 1'b0;
    tx_shift_busy = 1'b0;
    tx_fifo_empty = 1'b1;
    rx_pin = 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_fifo();
    t_brk();
    end_of_test();
  end

  initial
  begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    end_of_test();
  end
endmodule : testbench
